// ===== hdl/mios_pkg.sv
// Package of constants and types for the multiplexed I/O scanner
package mios_pkg;

   // Register byte offsets
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_STATUS = 6'h04;
   localparam logic [5:0] REG_MASK = 6'h08;
   localparam logic [5:0] REG_SWITCH_LO = 6'h0c;
   localparam logic [5:0] REG_SWITCH_HI = 6'h10;
   localparam logic [5:0] REG_MATRIX_0 = 6'h14;
   localparam logic [5:0] REG_DISP_SRC_LO = 6'h24;
   localparam logic [5:0] REG_DISP_SRC_HI = 6'h28;
   localparam logic [5:0] REG_STATE = 6'h2c;

   // Control register field positions
   localparam int CTRL_SW_EN = 0;
   localparam int CTRL_MX_EN = 1;
   localparam int CTRL_DISP_EN = 2;
   localparam int CTRL_DIGIT_COUNT = 4;
   localparam int CTRL_DISP_MODE_LSB = 8;
   localparam int CTRL_TICK_DIV_LSB = 16;

   // Values after reset
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] TICK_DIV_RESET = 16'h0000;

   // Round lengths in scan cycles
   localparam logic [4:0] SW_ROUND = 5'h10;
   localparam logic [4:0] MX_ROUND = 5'h18;
   localparam logic [4:0] DISP_ROUND = 5'h0c;

   // Digit-count operand values
   localparam logic [15:0] DIGITS_FOUR = 16'h0000;
   localparam logic [15:0] DIGITS_EIGHT = 16'h0001;

   // Output word bit positions
   localparam int SW_FLAG_BIT = 5;
   localparam int MX_FLAG_BIT = 8;
   localparam int DISP_FLAG4_BIT = 8;
   localparam int DISP_FLAG8_BIT = 12;

   // Display control bits
   localparam int DISP_LATCH_INV = 0;
   localparam int DISP_DATA_INV = 1;
   localparam int DISP_EIGHT = 2;

   // Status bit positions
   localparam int ST_SW_ROUND = 0;
   localparam int ST_MX_ROUND = 1;
   localparam int ST_DISP_ROUND = 2;

   // Active function select
   typedef enum logic [1:0] {
      MIOS_IDLE = 2'b00,
      MIOS_SWITCH = 2'b01,
      MIOS_MATRIX = 2'b10,
      MIOS_DISPLAY = 2'b11
   } mios_func_t;

endpackage

// ===== hdl/mios_scanner.sv
// Multiplexed switch, matrix and segment-display scanner with Avalon-MM slave
// Functional notes
// - Four digits when digit operand is 0000 hex, eight when 0001 hex.
// - Switch select and strobe on out bits 0-4; data stored in one or two words.
// - Switch reader completes one full read every 16 ticks, then repeats.
// - Switch round flag on out bit 5 once per 16 ticks.
// - Switch reader restarts from its first tick whenever started.
// - Matrix drives eight selects on out 0-7, reads in 0-7, 64 bits stored.
// - Matrix captures full 64-bit state once every 24 ticks.
// - Matrix round flag on out bit 8 for one tick in every 24.
// - Matrix scan begins at first row whenever started.
// - Display converts four or eight BCD digits from one or two words.
// - Display control picks digit count, latch and data polarity.
// - Display outputs all digits over twelve ticks, then reloads source.
// - Four-digit and eight-digit data, latch and flag bit placements.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
module mios_scanner
   import mios_pkg::*;
(
   input wire logic clk_in, // System clock, 200 MHz
   input wire logic rst_in, // Async reset, active high
   input wire logic [5:0] avs_address_in, // Byte address
   input wire logic avs_read_in, // Read request
   input wire logic avs_write_in, // Write request
   input wire logic [31:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Byte lanes
   output logic [31:0] avs_readdata_out, // Read data
   output logic avs_waitrequest_out, // Stall
   input wire logic [7:0] scan_in, // External input word bits 0-7
   output logic [15:0] scan_out, // External output word
   output logic irq_out // Level interrupt
);

   ////////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl, next_ctrl;
   logic [2:0] status, next_status;
   logic [2:0] mask, next_mask;
   logic [31:0] sw_result, next_sw_result;
   logic [63:0] mx_result, next_mx_result;
   logic [31:0] disp_src, next_disp_src;
   logic [31:0] disp_latched, next_disp_latched;
   logic [4:0] step, next_step;
   logic state_valid, next_state_valid;
   mios_func_t func, next_func;
   logic [15:0] out_word, next_out_word;
   logic [31:0] rdata, next_rdata;
   logic rack, next_rack;
   logic [7:0] in_meta, in_sync;
   logic tick;
   logic [2:0] round_evt;

   // Two flops on the external input before any use
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         in_meta <= 8'h00;
         in_sync <= 8'h00;
      end else begin
         in_meta <= scan_in;
         in_sync <= in_meta;
      end
   end

   mios_tick_gen u_mios_tick_gen (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .div_in(ctrl[CTRL_TICK_DIV_LSB +: 16]),
      .tick_out(tick)
   );

   // Byte-lane merge for software writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // BCD digit to seven-segment pattern, gfedcba
   function automatic logic [6:0] seg7(input logic [3:0] d);
      unique case (d)
         4'h0: seg7 = 7'h3f;
         4'h1: seg7 = 7'h06;
         4'h2: seg7 = 7'h5b;
         4'h3: seg7 = 7'h4f;
         4'h4: seg7 = 7'h66;
         4'h5: seg7 = 7'h6d;
         4'h6: seg7 = 7'h7d;
         4'h7: seg7 = 7'h27;
         4'h8: seg7 = 7'h7f;
         4'h9: seg7 = 7'h6f;
         4'ha: seg7 = 7'h77;
         4'hb: seg7 = 7'h7c;
         4'hc: seg7 = 7'h39;
         4'hd: seg7 = 7'h5e;
         4'he: seg7 = 7'h79;
         4'hf: seg7 = 7'h71;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic wr_hit;
   logic [7:0] seg_unused;
   assign wr_hit = avs_write_in;
   assign seg_unused = {1'b0, seg7(disp_latched[3:0])};
   assign avs_waitrequest_out = avs_read_in & ~rack;
   assign avs_readdata_out = rdata;
   assign scan_out = out_word;
   assign irq_out = |(status & mask);

   // Register file, status and readback
   always_comb begin
      next_ctrl = ctrl;
      next_mask = mask;
      next_disp_src = disp_src;
      next_state_valid = state_valid;
      next_status = status & ~(wr_hit && avs_address_in == REG_STATUS ? avs_writedata_in[2:0] : 3'h0);
      next_status = next_status | round_evt; // Set beats a same-cycle clear
      next_rack = avs_read_in & ~rack;
      next_rdata = rdata;
      if (wr_hit) begin
         unique case (avs_address_in)
            REG_CTRL: next_ctrl = merge(ctrl, avs_writedata_in, avs_byteenable_in);
            REG_MASK: next_mask = avs_writedata_in[2:0];
            REG_DISP_SRC_LO: next_disp_src[15:0] = avs_writedata_in[15:0];
            REG_DISP_SRC_HI: next_disp_src[31:16] = avs_writedata_in[15:0];
            REG_STATE: next_state_valid = avs_writedata_in == 32'h0000_0000;
            default: next_mask = mask;
         endcase
      end
      if (avs_read_in & ~rack) begin
         unique case (avs_address_in)
            REG_CTRL: next_rdata = ctrl;
            REG_STATUS: next_rdata = {29'h0, status};
            REG_MASK: next_rdata = {29'h0, mask};
            REG_SWITCH_LO: next_rdata = {16'h0, sw_result[15:0]};
            REG_SWITCH_HI: next_rdata = {16'h0, sw_result[31:16]};
            REG_MATRIX_0: next_rdata = {16'h0, mx_result[15:0]};
            REG_MATRIX_0 + 6'h04: next_rdata = {16'h0, mx_result[31:16]};
            REG_MATRIX_0 + 6'h08: next_rdata = {16'h0, mx_result[47:32]};
            REG_MATRIX_0 + 6'h0c: next_rdata = {16'h0, mx_result[63:48]};
            REG_DISP_SRC_LO: next_rdata = {16'h0, disp_src[15:0]};
            REG_DISP_SRC_HI: next_rdata = {16'h0, disp_src[31:16]};
            REG_STATE: next_rdata = {16'h0, out_word};
            default: next_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl <= CTRL_RESET;
         mask <= 3'h0;
         status <= 3'h0;
         disp_src <= 32'h0000_0000;
         state_valid <= 1'b0;
         rack <= 1'b0;
         rdata <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         mask <= next_mask;
         status <= next_status;
         disp_src <= next_disp_src;
         state_valid <= next_state_valid;
         rack <= next_rack;
         rdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scan engines share one step counter; only one function runs at a time
   mios_func_t want;
   logic [2:0] dmode;
   logic [2:0] digit;
   logic [7:0] sample;
   assign dmode = ctrl[CTRL_DISP_MODE_LSB +: 3];
   always_comb begin
      if (!state_valid) begin
         want = MIOS_IDLE;
      end else if (ctrl[CTRL_SW_EN]) begin
         want = MIOS_SWITCH;
      end else if (ctrl[CTRL_MX_EN]) begin
         want = MIOS_MATRIX;
      end else if (ctrl[CTRL_DISP_EN]) begin
         want = MIOS_DISPLAY;
      end else begin
         want = MIOS_IDLE;
      end
   end

   always_comb begin
      next_func = func;
      next_step = step;
      next_out_word = out_word;
      next_sw_result = sw_result;
      next_mx_result = mx_result;
      next_disp_latched = disp_latched;
      round_evt = 3'h0;
      digit = step[3:1];
      sample = in_sync;
      if (want != func) begin
         next_func = want;
         next_step = 5'h00;
         next_out_word = 16'h0000;
         next_disp_latched = disp_src;
      end else if (tick) begin
         next_out_word = 16'h0000;
         unique case (func)
            MIOS_SWITCH: begin
               // Even step selects a digit, odd step samples it
               if (step[0] == 1'b0 && step < 5'h10) begin
                  next_out_word[3:0] = {1'b0, step[3:1]} & 4'h7;
                  next_out_word[4] = 1'b1;
               end else begin
                  if (ctrl[CTRL_DIGIT_COUNT +: 16] == DIGITS_EIGHT || digit < 3'h4) begin
                     next_sw_result[digit*4 +: 4] = sample[3:0];
                  end
               end
               if (step == SW_ROUND - 5'h01) begin
                  next_out_word[SW_FLAG_BIT] = 1'b1;
                  round_evt[ST_SW_ROUND] = 1'b1;
                  next_step = 5'h00;
               end else begin
                  next_step = step + 5'h01;
               end
            end
            MIOS_MATRIX: begin
               // Rows 0-7 over steps 0-15 select then sample; rest idle
               if (step < 5'h10) begin
                  if (step[0] == 1'b0) begin
                     next_out_word[step[3:1]] = 1'b1;
                  end else begin
                     next_mx_result[digit*8 +: 8] = sample;
                  end
               end
               if (step == MX_ROUND - 5'h01) begin
                  next_out_word[MX_FLAG_BIT] = 1'b1;
                  round_evt[ST_MX_ROUND] = 1'b1;
                  next_step = 5'h00;
               end else begin
                  next_step = step + 5'h01;
               end
            end
            MIOS_DISPLAY: begin
               // Steps 0-7 drive data then pulse latch for digits 0-3
               if (step < 5'h08) begin
                  if (dmode[DISP_EIGHT]) begin
                     next_out_word[3:0] = disp_latched[step[2:1]*4 +: 4];
                     next_out_word[7:4] = disp_latched[16 + step[2:1]*4 +: 4];
                     next_out_word[8 + step[2:1]] = step[0];
                  end else begin
                     next_out_word[3:0] = disp_latched[step[2:1]*4 +: 4];
                     next_out_word[4 + step[2:1]] = step[0];
                  end
               end
               if (dmode[DISP_DATA_INV]) begin
                  next_out_word[7:0] = next_out_word[7:0] ^ (dmode[DISP_EIGHT] ? 8'hff : 8'h0f);
               end
               if (dmode[DISP_LATCH_INV]) begin
                  next_out_word[11:4] = next_out_word[11:4] ^ (dmode[DISP_EIGHT] ? 8'hf0 : 8'h0f);
               end
               if (step == DISP_ROUND - 5'h01) begin
                  next_out_word[dmode[DISP_EIGHT] ? DISP_FLAG8_BIT : DISP_FLAG4_BIT] = 1'b1;
                  round_evt[ST_DISP_ROUND] = 1'b1;
                  next_step = 5'h00;
                  next_disp_latched = disp_src;
               end else begin
                  next_step = step + 5'h01;
               end
            end
            MIOS_IDLE: begin
               next_step = 5'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         func <= MIOS_IDLE;
         step <= 5'h00;
         out_word <= 16'h0000;
         sw_result <= 32'h0000_0000;
         mx_result <= 64'h0;
         disp_latched <= 32'h0000_0000;
      end else begin
         func <= next_func;
         step <= next_step;
         out_word <= next_out_word;
         sw_result <= next_sw_result;
         mx_result <= next_mx_result;
         disp_latched <= next_disp_latched;
      end
   end

endmodule

// ===== hdl/mios_tick_gen.sv
// Scan-cycle tick generator: one pulse every div+1 clocks
module mios_tick_gen
   import mios_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire logic rst_in, // Async reset, active high
   input wire logic [15:0] div_in, // Clocks per tick minus one
   output logic tick_out // One-cycle scan tick
);

   logic [15:0] count;
   logic [15:0] next_count;

   // Count up and wrap once the divider value is reached
   always_comb begin
      if (count >= div_in) begin
         next_count = 16'h0000;
      end else begin
         next_count = count + 16'h0001;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count <= 16'h0000;
      end else begin
         count <= next_count;
      end
   end

   assign tick_out = (count >= div_in);

endmodule

// ===== testbench/mios_far_side.sv
// Far-side model: thumbwheel switch, key matrix and latched digit display
module mios_far_side
   import mios_pkg::*;
(
   input wire logic clk_in, // Clock
   input wire logic [15:0] word_in, // Scanner output word
   input wire logic keypad_in, // Keypad fitted instead of switch
   input wire logic [31:0] digits_in, // Switch digit k in nibble k
   input wire logic [63:0] keys_in, // Key row k in byte k
   input wire logic [2:0] mode_in, // Display wiring mode
   output logic [7:0] ret_out, // Return lines
   output logic [31:0] shown_out // Digits held by the display
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] rows;
   logic [3:0] lat;
   // Answers at once, well inside one tick; idle lines sit on pull-downs
   always_comb begin
      rows = 8'h00;
      for (int k = 0; k < 8; k++) begin
         if (word_in[k]) rows = rows | keys_in[8*k +: 8];
      end
      // Switch drives its data only while read-strobed; otherwise the pull-downs win
      ret_out = keypad_in ? rows : {4'h0, word_in[4] ? digits_in[4*word_in[2:0] +: 4] : 4'h0};
      lat = (mode_in[2] ? word_in[11:8] : word_in[7:4]) ^ {4{mode_in[0]}};
   end
   // Display latches are transparent while enabled
   always_ff @(posedge clk_in) begin
      for (int i = 0; i < 4; i++) begin
         if (lat[i]) begin
            shown_out[4*i +: 4] <= word_in[3:0] ^ {4{mode_in[1]}};
            if (mode_in[2]) shown_out[16+4*i +: 4] <= word_in[7:4] ^ {4{mode_in[1]}};
         end
      end
   end
endmodule

// ===== testbench/mios_scanner_props.sv
// Port-level checker for the multiplexed I/O scanner
module mios_scanner_props
   import mios_pkg::*;
(
   input wire logic clk_in, // Clock
   input wire logic rst_in, // Reset
   input wire logic [5:0] avs_address_in, // Address
   input wire logic avs_read_in, // Read
   input wire logic avs_write_in, // Write
   input wire logic [31:0] avs_writedata_in, // Write data
   input wire logic [3:0] avs_byteenable_in, // Lanes
   input wire logic [31:0] avs_readdata_out, // Read data
   input wire logic avs_waitrequest_out, // Stall
   input wire logic [7:0] scan_in, // Return lines
   input wire logic [15:0] scan_out, // Output word
   input wire logic irq_out // Interrupt
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] ctrl_q;
   logic [2:0] mask_q;
   logic armed, ever, sw, mx, flag, flag_d, rise, run, calm;
   logic [1:0] seen;
   logic [5:0] cnt, per;
   logic [3:0] quiet;
   // Flag bit and round length of the enabled function; the first rise after a change may be stale
   always_comb begin
      sw = ctrl_q[CTRL_SW_EN];
      mx = !sw && ctrl_q[CTRL_MX_EN];
      calm = armed && quiet == 4'hf;
      run = armed && ctrl_q[31:16] == 16'h0000 && seen[1];
      flag = 1'b0;
      per = 6'h00;
      if (sw) begin
         flag = scan_out[SW_FLAG_BIT];
         per = {1'b0, SW_ROUND};
      end else if (mx) begin
         flag = scan_out[MX_FLAG_BIT];
         per = {1'b0, MX_ROUND};
      end else if (ctrl_q[CTRL_DISP_EN]) begin
         flag = scan_out[ctrl_q[CTRL_DISP_MODE_LSB + DISP_EIGHT] ? DISP_FLAG8_BIT : DISP_FLAG4_BIT];
         per = {1'b0, DISP_ROUND};
      end
      rise = flag && !flag_d;
   end
   // Shadow of software writes; control or state writes restart the watch
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= CTRL_RESET;
         mask_q <= 3'h0;
         armed <= 1'b0;
         ever <= 1'b0;
         flag_d <= 1'b1;
         seen <= 2'h0;
         cnt <= 6'h00;
         quiet <= 4'h0;
      end else if (avs_write_in && (avs_address_in == REG_CTRL || avs_address_in == REG_STATE)) begin
         if (avs_address_in == REG_CTRL) ctrl_q <= avs_writedata_in;
         else armed <= avs_writedata_in == 32'h0;
         ever <= ever || (avs_address_in == REG_STATE && avs_writedata_in == 32'h0);
         flag_d <= 1'b1;
         seen <= 2'h0;
         quiet <= 4'h0;
      end else begin
         if (avs_write_in && avs_address_in == REG_MASK) mask_q <= avs_writedata_in[2:0];
         flag_d <= flag;
         seen <= (rise && !seen[1]) ? seen + 2'h1 : seen;
         cnt <= rise ? 6'h01 : (cnt == 6'h3f ? cnt : cnt + 6'h01);
         quiet <= quiet == 4'hf ? quiet : quiet + 4'h1;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   wr_no_stall_a: assert property (avs_write_in |-> !avs_waitrequest_out)
      else $error("write stalled");
   rd_one_wait_a: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
      else $error("read wait not one cycle");
   unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in > REG_STATE
      |-> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   round_period_a: assert property (rise && run |-> cnt == per)
      else $error("round length wrong");
   flag_one_tick_a: assert property (rise && run |=> !flag)
      else $error("round flag too long");
   unarmed_quiet_a: assert property (!ever |-> scan_out == 16'h0000)
      else $error("scanning before state cleared");
   mx_select_a: assert property (mx && calm |-> $onehot0(scan_out[7:0]) && scan_out[15:9] == 7'h00)
      else $error("matrix selects wrong");
   sw_bits_a: assert property (sw && calm |-> scan_out[15:6] == 10'h000)
      else $error("switch drives extra bits");
   irq_masked_a: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_out)
      else $error("masked interrupt raised");
   round_seen_c: cover property (rise && run);
   matrix_run_c: cover property (mx && calm);
   irq_seen_c: cover property (irq_out);
endmodule
bind mios_scanner mios_scanner_props u_mios_scanner_props (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
   .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .scan_in,
   .scan_out, .irq_out);

// ===== testbench/tb_mios_scanner.sv
// Self-checking bench for the multiplexed I/O scanner
module tb_mios_scanner
   import mios_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [5:0] adr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic mx = 1'b0;
   logic [2:0] dmode = 3'h0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] digits = 32'h8765_4321;
   logic [63:0] keys = 64'h8421_0f5a_c396_7e01;
   logic [31:0] rdat, q, shown;
   logic wreq, irq;
   logic [15:0] sout;
   logic [7:0] sin;
   int error_cnt = 0;
   int checked = 0;
   int d1, d2;
   always #2.5 clk_in = ~clk_in;
   mios_scanner u_mios_scanner (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
      .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdat),
      .avs_waitrequest_out(wreq), .scan_in(sin), .scan_out(sout), .irq_out(irq));
   mios_far_side u_mios_far_side (.clk_in(clk_in), .word_in(sout), .keypad_in(mx), .digits_in(digits),
      .keys_in(keys), .mode_in(dmode), .ret_out(sin), .shown_out(shown));
   ////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus cycle held until waitrequest is seen low; a hang ends the run
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_in);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         check(32'h0, 32'h1);
         summarize();
      end
   endtask
   // Cycles until the given output bit rises
   task automatic wait_rise(input int b, output int n);
      logic p;
      logic hit;
      p = 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
         hit = sout[b] === 1'b1 && p === 1'b0;
         p = sout[b];
      end while (!hit && n < 2000);
      if (!hit) begin
         check(32'h0, 32'h1);
         summarize();
      end
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      // Reset value, unmapped read, no scanning before the state word is cleared
      bus(1'b0, REG_CTRL, 32'h0);
      check(q, CTRL_RESET);
      bus(1'b0, 6'h30, 32'h0);
      check(q, 32'h0);
      bus(1'b1, REG_CTRL, 32'h0010_0001);
      repeat (40) @(posedge clk_in);
      check({16'h0, sout}, 32'h0);
      bus(1'b1, REG_STATE, 32'h0);
      $display("reset test done");
      // Seventeen clocks per tick, so a strobed digit passes the synchroniser within its tick
      repeat (3) wait_rise(SW_FLAG_BIT, d1);
      bus(1'b0, REG_SWITCH_LO, 32'h0);
      check(q, 32'h4321);
      bus(1'b0, REG_SWITCH_HI, 32'h0);
      check(q, 32'h0);
      digits <= 32'h2468_1357;
      bus(1'b1, REG_CTRL, 32'h0010_0011);
      repeat (3) wait_rise(SW_FLAG_BIT, d1);
      bus(1'b0, REG_SWITCH_LO, 32'h0);
      check(q, 32'h1357);
      bus(1'b0, REG_SWITCH_HI, 32'h0);
      check(q, 32'h2468);
      $display("switch test done");
      // Matrix at four clocks per tick, so the synchroniser keeps up
      mx <= 1'b1;
      bus(1'b1, REG_CTRL, 32'h0003_0002);
      repeat (3) wait_rise(MX_FLAG_BIT, d1);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, REG_MATRIX_0 + 6'(4 * i), 32'h0);
         check(q, {16'h0, keys[16*i +: 16]});
      end
      mx <= 1'b0;
      $display("matrix test done");
      // Every display control value, then a source change while running
      bus(1'b1, REG_DISP_SRC_LO, 32'h1234);
      bus(1'b1, REG_DISP_SRC_HI, 32'h5678);
      for (int i = 0; i < 8; i++) begin
         dmode <= 3'(i);
         bus(1'b1, REG_CTRL, 32'h4 | (32'(i) << 8));
         repeat (2) wait_rise(i > 3 ? DISP_FLAG8_BIT : DISP_FLAG4_BIT, d1);
         check({16'h0, shown[15:0]}, 32'h1234);
         if (i > 3) check({16'h0, shown[31:16]}, 32'h5678);
      end
      bus(1'b1, REG_DISP_SRC_LO, 32'h0909);
      repeat (2) wait_rise(DISP_FLAG8_BIT, d1);
      check({16'h0, shown[15:0]}, 32'h0909);
      $display("display test done");
      // A restart mid-round takes as long to the flag as a fresh start
      for (int i = 1; i < 3; i++) begin
         bus(1'b1, REG_CTRL, 32'h0);
         bus(1'b1, REG_CTRL, 32'(i));
         wait_rise(i == 1 ? SW_FLAG_BIT : MX_FLAG_BIT, d1);
         repeat (7) @(posedge clk_in);
         bus(1'b1, REG_CTRL, 32'h0);
         bus(1'b1, REG_CTRL, 32'(i));
         wait_rise(i == 1 ? SW_FLAG_BIT : MX_FLAG_BIT, d2);
         check(d2, d1);
      end
      $display("restart test done");
      // Interrupt raised, masked off, then cleared by writing one
      bus(1'b1, REG_CTRL, 32'h0);
      bus(1'b1, REG_STATUS, 32'h7);
      bus(1'b1, REG_MASK, 32'h1);
      bus(1'b1, REG_CTRL, 32'h1);
      wait_rise(SW_FLAG_BIT, d1);
      bus(1'b0, REG_STATUS, 32'h0);
      check({31'h0, q[0]}, 32'h1);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, REG_MASK, 32'h0);
      bus(1'b0, REG_MASK, 32'h0);
      check({31'h0, irq}, 32'h0);
      bus(1'b1, REG_CTRL, 32'h0);
      bus(1'b1, REG_STATUS, 32'h1);
      bus(1'b1, REG_MASK, 32'h1);
      bus(1'b0, REG_STATUS, 32'h0);
      check(q, 32'h0);
      check({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      summarize();
   end
endmodule
